// *** hw/i2c_master_pkg.sv ***
// constants and types shared by the two-wire bus master
package i2c_master_pkg;
    // ------------------------------------------------------------
    // bus timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ       = 100_000_000;
    localparam int unsigned MAX_BIT_RATE_BPS = 400_000;
    // quarter bit period in system cycles, rounded up so the rate stays at or below the limit
    localparam int unsigned QUARTER_CYCLES   =
        (SYS_CLK_HZ + 4 * MAX_BIT_RATE_BPS - 1) / (4 * MAX_BIT_RATE_BPS);
    localparam int unsigned QUARTER_W        = 8;

    // ------------------------------------------------------------
    // device address byte and register pointer
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR      = 7'h75;
    localparam logic       DIR_WRITE        = 1'b0;
    localparam logic       DIR_READ         = 1'b1;
    localparam logic [6:0] POINTER_LAST     = 7'h4f;
    localparam int unsigned POINTER_MSB     = 7;

    // ------------------------------------------------------------
    // bit engine commands and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_START = 3'h0,
        CMD_STOP  = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_READ  = 3'h3
    } bit_cmd_t;

    typedef enum logic [9:0] {
        ST_IDLE     = 10'h001,
        ST_START    = 10'h002,
        ST_SEL_W    = 10'h004,
        ST_POINTER  = 10'h008,
        ST_DATA_W   = 10'h010,
        ST_RESTART  = 10'h020,
        ST_SEL_R    = 10'h040,
        ST_DATA_R   = 10'h080,
        ST_STOP     = 10'h100,
        ST_DONE     = 10'h200
    } seq_state_t;
endpackage

// *** hw/byte_link_if.sv ***
// command and result signals between the transfer sequencer and the bit engine
`timescale 1ns/10ps
interface byte_link_if;
    logic                      cmd_valid;
    logic                      cmd_ready;
    i2c_master_pkg::bit_cmd_t  cmd;
    logic [7:0]                wdata;
    logic                      send_nack;
    logic                      rsp_valid;
    logic [7:0]                rdata;
    logic                      ack_seen;

    modport seq (
        output cmd_valid,
        input  cmd_ready,
        output cmd,
        output wdata,
        output send_nack,
        input  rsp_valid,
        input  rdata,
        input  ack_seen
    );
    modport eng (
        input  cmd_valid,
        output cmd_ready,
        input  cmd,
        input  wdata,
        input  send_nack,
        output rsp_valid,
        output rdata,
        output ack_seen
    );
endinterface

// *** hw/i2c_bit_engine.sv ***
// bit level engine: start, stop, byte write and byte read on the two-wire bus
`timescale 1ns/10ps
module i2c_bit_engine (
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    byte_link_if.eng             link,
    input  wire logic            sda_sync_in,
    output logic                 scl_oe_out,
    output logic                 sda_oe_out
);
    typedef enum logic [3:0] {
        EB_IDLE = 4'h1,
        EB_RUN  = 4'h2,
        EB_RSP  = 4'h4,
        EB_HOLD = 4'h8
    } eng_state_t;

    eng_state_t                  state;
    eng_state_t                  next_state;
    i2c_master_pkg::bit_cmd_t    cmd;
    i2c_master_pkg::bit_cmd_t    next_cmd;
    logic [7:0]                  tick;
    logic [7:0]                  next_tick;
    logic [1:0]                  phase;
    logic [1:0]                  next_phase;
    logic [3:0]                  bitn;
    logic [3:0]                  next_bitn;
    logic [8:0]                  shreg;
    logic [8:0]                  next_shreg;
    logic                        scl_low;
    logic                        next_scl_low;
    logic                        sda_low;
    logic                        next_sda_low;
    logic                        last_q;
    logic                        last_bit;

    assign scl_oe_out      = scl_low;
    assign sda_oe_out      = sda_low;
    assign link.cmd_ready  = (state == EB_IDLE) || (state == EB_HOLD);
    assign link.rsp_valid  = (state == EB_RSP);
    assign link.rdata      = shreg[8:1];
    assign link.ack_seen   = ~shreg[0];
    assign last_q          = (tick == 8'(i2c_master_pkg::QUARTER_CYCLES - 1));
    assign last_bit        = (cmd == i2c_master_pkg::CMD_START) ||
                             (cmd == i2c_master_pkg::CMD_STOP) || (bitn == 4'h8);

    always_comb begin
        next_state   = state;
        next_cmd     = cmd;
        next_tick    = tick;
        next_phase   = phase;
        next_bitn    = bitn;
        next_shreg   = shreg;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        case (state)
            EB_IDLE, EB_HOLD: begin
                if (link.cmd_valid) begin
                    next_state = EB_RUN;
                    next_cmd   = link.cmd;
                    next_tick  = 8'h00;
                    next_phase = 2'h0;
                    next_bitn  = 4'h0;
                    if (link.cmd == i2c_master_pkg::CMD_WRITE) begin
                        next_shreg = {link.wdata, 1'b1};
                    end else begin
                        next_shreg = {8'hff, link.send_nack};
                    end
                end
            end
            EB_RUN: begin
                next_tick = last_q ? 8'h00 : 8'(tick + 8'h01);
                if (last_q) begin
                    next_phase = 2'(phase + 2'h1);
                    case (cmd)
                        i2c_master_pkg::CMD_START: begin
                            // phase0 release data, 1 raise clock, 2 data falls, 3 clock falls
                            case (phase)
                                2'h0: next_sda_low = 1'b0;
                                2'h1: next_scl_low = 1'b0;
                                2'h2: next_sda_low = 1'b1;
                                default: next_scl_low = 1'b1;
                            endcase
                        end
                        i2c_master_pkg::CMD_STOP: begin
                            case (phase)
                                2'h0: next_sda_low = 1'b1;
                                2'h1: next_scl_low = 1'b0;
                                2'h2: next_sda_low = 1'b0;
                                default: next_sda_low = 1'b0;
                            endcase
                        end
                        default: begin
                            case (phase)
                                2'h0: next_sda_low = ~shreg[8];
                                2'h1: next_scl_low = 1'b0;
                                2'h2: next_shreg   = {shreg[7:0], sda_sync_in};
                                default: begin
                                    next_scl_low = 1'b1;
                                    next_bitn    = 4'(bitn + 4'h1);
                                end
                            endcase
                        end
                    endcase
                    if (phase == 2'h3 && last_bit) begin
                        next_state = EB_RSP;
                    end
                end
            end
            EB_RSP: begin
                next_state = EB_HOLD;
                // release data after a byte so the far end or a stop may drive it
                if (cmd != i2c_master_pkg::CMD_START) begin
                    next_sda_low = 1'b0;
                end
            end
            default: next_state = EB_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state   <= EB_IDLE;
            cmd     <= i2c_master_pkg::CMD_STOP;
            tick    <= 8'h00;
            phase   <= 2'h0;
            bitn    <= 4'h0;
            shreg   <= 9'h1ff;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else begin
            state   <= next_state;
            cmd     <= next_cmd;
            tick    <= next_tick;
            phase   <= next_phase;
            bitn    <= next_bitn;
            shreg   <= next_shreg;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
        end
    end
endmodule

// *** hw/i2c_reg_master.sv ***
// two-wire bus master that writes and reads registers of the display encoder
// Function
// - only the master drives the clock
// - open-drain lines, idle high
// - bit rate at most 400 kbit/s
// - data falling, clock high: start
// - data changes only while clock low
// - data rising, clock high: stop
// - transmitter releases data during acknowledge clock
// - alternating write: pointer before each data
// - stop or restart ends auto-increment
// - master withholds acknowledge on last read
// - read: select, pointer, restart, select read
// - alternating read: restart and select each step
`timescale 1ns/10ps
module i2c_reg_master (
    input  wire logic            sys_clk_in,
    input  wire logic            rst_in,
    input  wire logic            req_valid_in,
    output logic                 req_ready_out,
    input  wire logic            req_read_in,
    input  wire logic            pointer_step_mode_in,
    input  wire logic [6:0]      reg_index_in,
    input  wire logic [3:0]      count_in,
    input  wire logic [7:0]      wr_data_in,
    output logic                 wr_data_take_out,
    output logic                 rd_valid_out,
    output logic [7:0]           rd_data_out,
    output logic                 done_out,
    output logic                 nack_out,
    output logic                 serial_clock_pin_out,
    output logic                 serial_clock_pin_oe_out,
    input  wire logic            serial_data_pin_in,
    output logic                 serial_data_pin_out,
    output logic                 serial_data_pin_oe_out
);
    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    logic                        sda_meta;
    logic                        sda_sync;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            sda_meta <= serial_data_pin_in;
            sda_sync <= sda_meta;
        end
    end

    byte_link_if link ();

    i2c_bit_engine u_engine (
        .clk_in      (sys_clk_in),
        .rst_in      (rst_in),
        .link        (link),
        .sda_sync_in (sda_sync),
        .scl_oe_out  (serial_clock_pin_oe_out),
        .sda_oe_out  (serial_data_pin_oe_out)
    );

    assign serial_clock_pin_out = 1'b0;
    assign serial_data_pin_out  = 1'b0;

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    function automatic logic [7:0] select_byte(input logic dir);
        select_byte = {i2c_master_pkg::TARGET_ADDR, dir};
    endfunction

    function automatic logic [6:0] step_pointer(input logic [6:0] p);
        step_pointer = (p == i2c_master_pkg::POINTER_LAST) ? 7'h00 : 7'(p + 7'h01);
    endfunction

    i2c_master_pkg::seq_state_t  state;
    i2c_master_pkg::seq_state_t  next_state;
    logic                        issued;
    logic                        next_issued;
    logic                        is_read;
    logic                        next_is_read;
    logic                        auto_mode;
    logic                        next_auto_mode;
    logic [6:0]                  pointer;
    logic [6:0]                  next_pointer;
    logic [3:0]                  remain;
    logic [3:0]                  next_remain;
    logic [7:0]                  rd_data;
    logic [7:0]                  next_rd_data;
    logic                        rd_valid;
    logic                        next_rd_valid;
    logic                        done;
    logic                        next_done;
    logic                        nack;
    logic                        next_nack;
    logic                        pointer_sent;
    logic                        next_pointer_sent;
    logic                        last_byte;

    assign req_ready_out = (state == i2c_master_pkg::ST_IDLE);
    assign rd_valid_out  = rd_valid;
    assign rd_data_out   = rd_data;
    assign done_out      = done;
    assign nack_out      = nack;
    assign last_byte     = (remain == 4'h1);
    assign wr_data_take_out = (state == i2c_master_pkg::ST_DATA_W) && issued && link.rsp_valid;

    always_comb begin
        next_state        = state;
        next_issued       = issued;
        next_is_read      = is_read;
        next_auto_mode    = auto_mode;
        next_pointer      = pointer;
        next_remain       = remain;
        next_rd_data      = rd_data;
        next_rd_valid     = 1'b0;
        next_done         = 1'b0;
        next_nack         = nack;
        next_pointer_sent = pointer_sent;
        link.cmd_valid    = 1'b0;
        link.cmd          = i2c_master_pkg::CMD_STOP;
        link.wdata        = 8'hff;
        link.send_nack    = 1'b0;
        case (state)
            i2c_master_pkg::ST_IDLE: begin
                if (req_valid_in) begin
                    next_state     = i2c_master_pkg::ST_START;
                    next_is_read   = req_read_in;
                    next_auto_mode = pointer_step_mode_in;
                    next_pointer   = reg_index_in;
                    next_remain    = (count_in == 4'h0) ? 4'h1 : count_in;
                    next_nack      = 1'b0;
                    next_issued    = 1'b0;
                end
            end
            i2c_master_pkg::ST_START, i2c_master_pkg::ST_RESTART, i2c_master_pkg::ST_STOP,
            i2c_master_pkg::ST_SEL_W, i2c_master_pkg::ST_SEL_R, i2c_master_pkg::ST_POINTER,
            i2c_master_pkg::ST_DATA_W, i2c_master_pkg::ST_DATA_R: begin
                case (state)
                    i2c_master_pkg::ST_START, i2c_master_pkg::ST_RESTART:
                        link.cmd = i2c_master_pkg::CMD_START;
                    i2c_master_pkg::ST_STOP:
                        link.cmd = i2c_master_pkg::CMD_STOP;
                    i2c_master_pkg::ST_DATA_R:
                        link.cmd = i2c_master_pkg::CMD_READ;
                    default:
                        link.cmd = i2c_master_pkg::CMD_WRITE;
                endcase
                case (state)
                    i2c_master_pkg::ST_SEL_W:  link.wdata = select_byte(i2c_master_pkg::DIR_WRITE);
                    i2c_master_pkg::ST_SEL_R:  link.wdata = select_byte(i2c_master_pkg::DIR_READ);
                    i2c_master_pkg::ST_POINTER: link.wdata = {1'b0, pointer};
                    i2c_master_pkg::ST_DATA_W: link.wdata = wr_data_in;
                    default:                   link.wdata = 8'hff;
                endcase
                // each alternating read ends its own cycle, so its byte is not acknowledged
                link.send_nack = last_byte || !auto_mode;
                link.cmd_valid = ~issued;
                if (!issued && link.cmd_ready) begin
                    next_issued = 1'b1;
                end
                if (issued && link.rsp_valid) begin
                    next_issued = 1'b0;
                    case (state)
                        i2c_master_pkg::ST_START: begin
                            next_state        = i2c_master_pkg::ST_SEL_W;
                            next_pointer_sent = 1'b0;
                        end
                        i2c_master_pkg::ST_RESTART:
                            next_state = pointer_sent ? i2c_master_pkg::ST_SEL_R
                                                      : i2c_master_pkg::ST_SEL_W;
                        i2c_master_pkg::ST_STOP:
                            next_state = i2c_master_pkg::ST_DONE;
                        i2c_master_pkg::ST_SEL_W, i2c_master_pkg::ST_SEL_R: begin
                            if (!link.ack_seen) begin
                                next_nack  = 1'b1;
                                next_state = i2c_master_pkg::ST_STOP;
                            end else if (state == i2c_master_pkg::ST_SEL_R) begin
                                next_state = i2c_master_pkg::ST_DATA_R;
                            end else begin
                                next_state = i2c_master_pkg::ST_POINTER;
                            end
                        end
                        i2c_master_pkg::ST_POINTER: begin
                            next_pointer_sent = 1'b1;
                            if (!link.ack_seen) begin
                                next_nack  = 1'b1;
                                next_state = i2c_master_pkg::ST_STOP;
                            end else if (is_read) begin
                                next_state = i2c_master_pkg::ST_RESTART;
                            end else begin
                                next_state = i2c_master_pkg::ST_DATA_W;
                            end
                        end
                        i2c_master_pkg::ST_DATA_W: begin
                            next_remain = 4'(remain - 4'h1);
                            if (!link.ack_seen) begin
                                next_nack = 1'b1;
                            end
                            if (!link.ack_seen || last_byte) begin
                                next_state = i2c_master_pkg::ST_STOP;
                            end else if (auto_mode && pointer == i2c_master_pkg::POINTER_LAST) begin
                                // device takes the next byte as a fresh pointer
                                next_pointer = 7'h00;
                                next_state   = i2c_master_pkg::ST_POINTER;
                            end else if (auto_mode) begin
                                next_pointer = 7'(pointer + 7'h01);
                            end else begin
                                next_pointer = 7'(pointer + 7'h01);
                                next_state   = i2c_master_pkg::ST_POINTER;
                            end
                        end
                        default: begin
                            next_rd_data  = link.rdata;
                            next_rd_valid = 1'b1;
                            next_remain   = 4'(remain - 4'h1);
                            next_pointer  = step_pointer(pointer);
                            if (last_byte) begin
                                next_state = i2c_master_pkg::ST_STOP;
                            end else if (!auto_mode) begin
                                next_pointer_sent = 1'b0;
                                next_state        = i2c_master_pkg::ST_RESTART;
                            end
                        end
                    endcase
                end
            end
            i2c_master_pkg::ST_DONE: begin
                next_done  = 1'b1;
                next_state = i2c_master_pkg::ST_IDLE;
            end
            default: next_state = i2c_master_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state        <= i2c_master_pkg::ST_IDLE;
            issued       <= 1'b0;
            is_read      <= 1'b0;
            auto_mode    <= 1'b0;
            pointer      <= 7'h00;
            remain       <= 4'h0;
            rd_data      <= 8'h00;
            rd_valid     <= 1'b0;
            done         <= 1'b0;
            nack         <= 1'b0;
            pointer_sent <= 1'b0;
        end else begin
            state        <= next_state;
            issued       <= next_issued;
            is_read      <= next_is_read;
            auto_mode    <= next_auto_mode;
            pointer      <= next_pointer;
            remain       <= next_remain;
            rd_data      <= next_rd_data;
            rd_valid     <= next_rd_valid;
            done         <= next_done;
            nack         <= next_nack;
            pointer_sent <= next_pointer_sent;
        end
    end
endmodule

// *** dv/i2c_reg_master_assertions.sv ***
// checker for the two-wire register master
`timescale 1ns/10ps
module i2c_reg_master_chk (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic req_ready_out,
    input wire logic rd_valid_out,
    input wire logic done_out,
    input wire logic nack_out,
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe_out,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic [7:0] run;
    logic [7:0] next_run;
    logic       prev;
    wire        c = serial_clock_pin_oe_out;
    wire        d = serial_data_pin_oe_out;
    // cycles the clock enable has held its level
    always_comb next_run = (c != prev) ? 8'h00 : run + {7'h00, run != 8'hff};
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) {run, prev} <= {8'hff, 1'b0};
        else {run, prev} <= {next_run, c};
    end
    sequence s_start;
        !c && $rose(d);
    endsequence
    sequence s_stop;
        !c && $fell(d);
    endsequence
    property p_clk_drv; serial_clock_pin_out == 1'b0; endproperty
    property p_dat_drv; serial_data_pin_out == 1'b0; endproperty
    property p_idle; req_ready_out |-> !c && !d; endproperty
    property p_rate; c != prev |-> run >= 8'h3c; endproperty
    property p_start; s_start |-> d throughout ##[60:66] c; endproperty
    property p_bit; $changed(d) && c |-> c [*8]; endproperty
    property p_stop; s_stop |-> ##[0:130] done_out; endproperty
    property p_rd; rd_valid_out |-> !req_ready_out; endproperty
    property p_nack; $rose(nack_out) |-> ##[0:600] req_ready_out; endproperty
    a_clk_drv: assert property (p_clk_drv) else $error("clock level driven");
    a_dat_drv: assert property (p_dat_drv) else $error("data level driven");
    a_idle: assert property (p_idle) else $error("lines held in idle");
    a_rate: assert property (p_rate) else $error("clock phase too short");
    a_start: assert property (p_start) else $error("bad start");
    a_bit: assert property (p_bit) else $error("data moved near clock");
    a_stop: assert property (p_stop) else $error("stop without done");
    a_rd: assert property (p_rd) else $error("read byte while idle");
    a_nack: assert property (p_nack) else $error("no idle after nack");
endmodule
bind i2c_reg_master i2c_reg_master_chk i2c_reg_master_chk_i (.sys_clk_in, .rst_in,
    .req_ready_out, .rd_valid_out, .done_out, .nack_out, .serial_clock_pin_out,
    .serial_clock_pin_oe_out, .serial_data_pin_out, .serial_data_pin_oe_out);

// *** dv/enc_dev_model.sv ***
// behavioural register device on the two-wire bus
`timescale 1ns/10ps
module enc_dev_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic auto_in,
    input  wire logic mute_in,
    output logic      pull_out
);
    logic [7:0] mem [0:127];
    logic [7:0] sh;
    logic [6:0] ptr;
    logic       rd, tx, ak;
    int         n, ph;
    initial begin
        pull_out = 1'b0;
        ph = 3;
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
    end
    always @(negedge sda_in) if (scl_in) begin
        n = 0;
        ph = 0;
        {tx, rd} = 2'b00;
    end
    always @(posedge sda_in) if (scl_in) ph = 3;
    always @(posedge scl_in) if (ph != 3) begin
        if (n == 9) ak = !sda_in;
        else {sh, n} = {sh[6:0], sda_in, n + 1};
    end
    always @(negedge scl_in) if (ph != 3) begin
        if (n == 8) begin
            n = 9;
            pull_out = !tx;
            if (!tx) case (ph)
                0: if (mute_in || sh[7:1] != 7'h75) begin
                    ph = 3;
                    pull_out = 1'b0;
                end else begin
                    rd = sh[0];
                    ph = rd ? 2 : 1;
                end
                1: {ptr, ph} = {sh[6:0], 2};
                default: begin
                    mem[ptr] = sh;
                    if (!auto_in || ptr == 7'h4f) ph = 1;
                    else ptr = ptr + 7'h01;
                end
            endcase
        end else if (n == 9) begin
            n = 0;
            pull_out = 1'b0;
            if (rd && ph == 2) begin
                if (tx && !ak) ph = 3;
                else begin
                    if (tx) ptr = (ptr == 7'h4f) ? 7'h00 : ptr + 7'h01;
                    sh = mem[ptr];
                    tx = 1'b1;
                end
            end
        end
        if (tx && ph == 2 && n < 8) pull_out = !sh[7];
    end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the two-wire register master
`timescale 1ns/10ps
module tb_top;
    logic        clk, rst, vld, rdq, mode, mute, pull, pend;
    logic [6:0]  idx;
    logic [3:0]  cnt;
    logic [7:0]  wd;
    logic [15:0] rs;
    wire         rdy, take, rv, done, nack, scl_oe, sda_oe;
    wire  [7:0]  rdd;
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || pull);
    int          failures, n_compared;
    logic [7:0]  ex [0:127];
    logic [7:0]  wq [$];
    logic [7:0]  rq [$];
    i2c_reg_master i2c_reg_master_i (.sys_clk_in(clk), .rst_in(rst), .req_valid_in(vld),
        .req_ready_out(rdy), .req_read_in(rdq), .pointer_step_mode_in(mode),
        .reg_index_in(idx), .count_in(cnt), .wr_data_in(wd), .wr_data_take_out(take),
        .rd_valid_out(rv), .rd_data_out(rdd), .done_out(done), .nack_out(nack),
        .serial_clock_pin_out(), .serial_clock_pin_oe_out(scl_oe),
        .serial_data_pin_in(sda), .serial_data_pin_out(), .serial_data_pin_oe_out(sda_oe));
    enc_dev_model enc_dev_model_i (.scl_in(scl), .sda_in(sda), .auto_in(mode),
        .mute_in(mute), .pull_out(pull));
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic r, input logic m, input logic [6:0] i,
                        input logic [3:0] c);
        int k;
        logic [6:0] p;
        p = i;
        for (k = 0; k < ((c == 4'h0) ? 1 : c); k++) begin
            rs = lfsr(rs);
            if (!r) wq.push_back(rs[7:0]);
            if (r && !mute) rq.push_back(ex[p]);
            if (!r && !mute) ex[p] = rs[7:0];
            p = ((m || r) && p == 7'h4f) ? 7'h00 : p + 7'h01;
        end
        @(negedge clk);
        if (!r) wd = wq[0];
        {vld, rdq, mode, idx, cnt} = {1'b1, r, m, i, c};
        @(negedge clk);
        vld = 1'b0;
        for (k = 0; k < 40000 && done !== 1'b1; k++) begin
            @(negedge clk);
            if (pend && wq.size() > 1) begin
                void'(wq.pop_front());
                wd = wq[0];
            end
            pend = take;
            if (rv === 1'b1) chk(rdd, rq.pop_front());
        end
        chk({7'h00, done}, 8'h01);
        chk({7'h00, nack}, {7'h00, mute});
        chk(8'(rq.size()), 8'h00);
        for (k = 0; k < 80; k++) chk(enc_dev_model_i.mem[k], ex[k]);
        wq.delete();
    endtask
    initial begin
        {vld, rdq, mode, mute, pend, idx, cnt, wd} = '0;
        {failures, n_compared} = '0;
        rs = 16'h448d;
        rst = 1'b1;
        for (int i = 0; i < 128; i++) ex[i] = 8'(i * 37 + 5);
        repeat (2) @(negedge clk);
        rst = 1'b0;
        xfer(1'b0, 1'b1, 7'h4e, 4'h4);
        xfer(1'b0, 1'b0, 7'h10, 4'h2);
        xfer(1'b1, 1'b1, 7'h4e, 4'h3);
        xfer(1'b1, 1'b0, 7'h10, 4'h2);
        repeat (2) begin
            rs = lfsr(rs);
            xfer(rs[0], rs[1], {1'b0, rs[7:2]}, {3'h0, rs[8]});
        end
        mute = 1'b1;
        xfer(1'b0, 1'b1, 7'h20, 4'h1);
        mute = 1'b0;
        xfer(1'b1, 1'b0, 7'h20, 4'h0);
        report_and_stop();
    end
    initial begin
        #1300000;
        failures++;
        report_and_stop();
    end
endmodule
